// ==== vcu_ctrl.sv ====
// Board controller end: Avalon-MM registers, UART and hardware handshake
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module vcu_ctrl
    import vcu_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Serial link
    vcu_if.ctrl              lnk,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest
);
    typedef struct packed {
        logic [15:0] div;
        logic [1:0]  mode;
        logic        wrq;
        logic [31:0] rdata;
        logic [7:0]  hold;
        logic        hold_v;
        vcu_ln_t     tst;
        logic [9:0]  tsh;
        logic [3:0]  tbit;
        logic [15:0] tcnt;
        vcu_ln_t     rxst;
        logic [7:0]  rsh;
        logic [3:0]  rbit;
        logic [15:0] rcnt;
        logic        push;
        logic        ovr;
        logic        crdy;
        logic        crdy_oe;
    } vcu_ctrl_st_t;

    localparam vcu_ctrl_st_t RST_ST = '{
        div:     DIV_DEF,
        mode:    HS_DEF,
        wrq:     1'b1,
        rdata:   32'h0,
        hold:    8'h0,
        hold_v:  1'b0,
        tst:     LN_IDLE,
        tsh:     10'h3FF,
        tbit:    4'h0,
        tcnt:    16'h0,
        rxst:    LN_IDLE,
        rsh:     8'h0,
        rbit:    4'h0,
        rcnt:    16'h0,
        push:    1'b0,
        ovr:     1'b0,
        crdy:    1'b0,
        crdy_oe: 1'b0
    };

    vcu_ctrl_st_t s;
    vcu_ctrl_st_t next_s;
    logic         pop;
    logic         req;
    logic         tx_stall;
    logic [15:0]  wdiv;
    logic         f_in_ready;
    logic         f_out_valid;
    logic [7:0]   f_out_data;

    // Bytes from the target wait here until software reads them
    vcu_fifo #(
        .W     (8),
        .DEPTH (FIFO_DEPTH)
    ) u_rxbuf (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (s.push),
        .in_data   (s.rsh),
        .in_ready  (f_in_ready),
        .out_valid (f_out_valid),
        .out_data  (f_out_data),
        .out_ready (pop),
        .count     ()
    );

    always_comb begin
        next_s      = s;
        next_s.wrq  = 1'b1;
        next_s.push = 1'b0;
        pop         = 1'b0;
        wdiv        = avs_writedata[15:0];
        req         = (avs_read || avs_write) && s.wrq;
        // A byte written while one is still pending is held off by waitrequest
        tx_stall    = avs_write && (avs_address == REG_TXD) && s.hold_v;

        // Register access, one wait state per request except a TXD write stalled behind a pending byte
        if (req && !tx_stall) begin
            next_s.wrq   = 1'b0;
            next_s.rdata = 32'h0;
            if (avs_address == REG_CFG) begin
                if (avs_read) begin
                    next_s.rdata = {14'h0, s.mode, s.div};
                end
                if (avs_write && (avs_byteenable[1:0] == 2'h3)) begin
                    next_s.div = (wdiv < DIV_MIN) ? DIV_MIN :
                                 (wdiv > DIV_MAX) ? DIV_MAX : wdiv;
                end
                if (avs_write && avs_byteenable[2]) begin
                    next_s.mode = avs_writedata[CFG_MODE_LSB+1:CFG_MODE_LSB];
                end
            end else if (avs_address == REG_STAT) begin
                if (avs_read) begin
                    next_s.rdata = {26'h0, s.ovr, s.crdy, lnk.link_en, lnk.t_rdy,
                                    s.hold_v || (s.tst == LN_BUSY), f_out_valid};
                    next_s.ovr   = 1'b0;
                end
            end else if (avs_address == REG_TXD) begin
                if (avs_write && avs_byteenable[0]) begin
                    next_s.hold   = avs_writedata[7:0];
                    next_s.hold_v = 1'b1;
                end
            end else if (avs_address == REG_RXD) begin
                if (avs_read) begin
                    next_s.rdata = {23'h0, f_out_valid, f_out_data};
                    pop          = f_out_valid;
                end
            end
        end

        // Transmitter toward the target
        case (s.tst)
            LN_IDLE: begin
                // Target-ready only matters when mode bit 1 is set
                if (s.hold_v && lnk.link_en &&
                    (!s.mode[1] || lnk.t_rdy)) begin
                    next_s.tsh    = {1'b1, s.hold, 1'b0};
                    next_s.hold_v = 1'b0;
                    next_s.tbit   = FRAME_BITS - 4'h1;
                    next_s.tcnt   = s.div - 16'h1;
                    next_s.tst    = LN_BUSY;
                end
            end
            LN_BUSY: begin
                // Target-ready is not looked at mid-frame, so a byte always completes
                if (s.tcnt != 16'h0) begin
                    next_s.tcnt = s.tcnt - 16'h1;
                end else if (s.tbit == 4'h0) begin
                    next_s.tst = LN_IDLE;
                end else begin
                    next_s.tsh  = {1'b1, s.tsh[9:1]};
                    next_s.tbit = s.tbit - 4'h1;
                    next_s.tcnt = s.div - 16'h1;
                end
            end
            default: begin
                next_s.tst = LN_IDLE;
            end
        endcase

        // Receiver from the target, sampling at mid-bit
        case (s.rxst)
            LN_IDLE: begin
                if (lnk.link_en && !lnk.t2c) begin
                    next_s.rxst = LN_BUSY;
                    next_s.rcnt = {1'b0, s.div[15:1]};
                    next_s.rbit = 4'h0;
                end
            end
            LN_BUSY: begin
                if (s.rcnt != 16'h0) begin
                    next_s.rcnt = s.rcnt - 16'h1;
                end else begin
                    next_s.rcnt = s.div - 16'h1;
                    next_s.rbit = s.rbit + 4'h1;
                    if (s.rbit == 4'h0) begin
                        // A start bit gone high again was a glitch
                        if (lnk.t2c) begin
                            next_s.rxst = LN_IDLE;
                        end
                    end else if (s.rbit != FRAME_BITS - 4'h1) begin
                        next_s.rsh = {lnk.t2c, s.rsh[7:1]};
                    end else begin
                        next_s.rxst = LN_IDLE;
                        // Bad stop bit drops the byte; a full buffer drops it too
                        if (lnk.t2c) begin
                            next_s.push = 1'b1;
                            if (!f_in_ready) begin
                                next_s.ovr = 1'b1;
                            end
                        end
                    end
                end
            end
            default: begin
                next_s.rxst = LN_IDLE;
            end
        endcase

        // Flow output, driven only in the rts and rtscts modes
        next_s.crdy    = f_in_ready;
        next_s.crdy_oe = s.mode[0];
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s <= RST_ST;
        end else begin
            s <= next_s;
        end
    end

    assign lnk.c2t         = s.tsh[0];
    assign lnk.c_rdy_o     = s.crdy;
    assign lnk.c_rdy_oe    = s.crdy_oe;
    assign avs_readdata    = s.rdata;
    assign avs_waitrequest = s.wrq;
endmodule
`default_nettype wire

// ==== vcu_pkg.sv ====
// Shared constants and types for the virtual serial port link
// Function
// - Target sends on t2c, controller on c2t
// - Target enable gates all link traffic
// - Controller-ready high unless input buffer full
// - Target pauses sending while controller-ready low
// - Target-ready high while target can receive
// - Byte in progress finishes; target takes one more
// - Defaults: 115200 baud, 8N1, flow control off
// - Baud rate selectable from 9600 to 921600
// - Disabled mode: no ready drive, ignore target-ready
// - Rts mode: drive ready, ignore target-ready
// - Cts mode: no ready drive, honour target-ready
// - Rtscts mode: drive ready and honour target-ready
// - Target must drive target-ready when honoured
`default_nettype none
package vcu_pkg;
    localparam int          CLK_HZ     = 25_000_000;
    localparam int          BAUD_DEF   = 115_200;
    localparam int          BAUD_MIN   = 9_600;
    localparam int          BAUD_MAX   = 921_600;
    localparam logic [15:0] DIV_DEF    = 16'(CLK_HZ / BAUD_DEF);
    localparam logic [15:0] DIV_MIN    = 16'(CLK_HZ / BAUD_MAX);
    localparam logic [15:0] DIV_MAX    = 16'(CLK_HZ / BAUD_MIN);
    localparam logic [3:0]  FRAME_BITS = 4'hA;
    localparam int          FIFO_DEPTH = 2;
    // Handshake mode: bit 0 drives controller-ready, bit 1 honours target-ready
    localparam logic [1:0]  HS_DISABLED = 2'h0;
    localparam logic [1:0]  HS_RTS      = 2'h1;
    localparam logic [1:0]  HS_CTS      = 2'h2;
    localparam logic [1:0]  HS_RTSCTS   = 2'h3;
    localparam logic [1:0]  HS_DEF      = HS_DISABLED;
    // Register byte offsets
    localparam logic [3:0]  REG_CFG  = 4'h0;
    localparam logic [3:0]  REG_STAT = 4'h4;
    localparam logic [3:0]  REG_TXD  = 4'h8;
    localparam logic [3:0]  REG_RXD  = 4'hC;
    localparam int          CFG_MODE_LSB = 16;
    typedef enum logic [1:0] {
        LN_IDLE = 2'b01,
        LN_BUSY = 2'b10
    } vcu_ln_t;
endpackage
`default_nettype wire

// ==== vcu_if.sv ====
// Serial link between target and board controller
`timescale 1ns/1ps
`default_nettype none
interface vcu_if;
    logic t2c;
    logic c2t;
    logic c_rdy_o;
    logic c_rdy_oe;
    logic c_rdy;
    logic t_rdy;
    logic link_en;
    // Undriven controller-ready floats high through a pull-up
    assign c_rdy = c_rdy_oe ? c_rdy_o : 1'b1;
    modport ctrl (input t2c, t_rdy, link_en, output c2t, c_rdy_o, c_rdy_oe);
    modport tgt  (input c2t, c_rdy, output t2c, t_rdy, link_en);
endinterface
`default_nettype wire

// ==== vcu_fifo.sv ====
// Small valid/ready buffer for received bytes
`timescale 1ns/1ps
`default_nettype none
module vcu_fifo
    import vcu_pkg::*;
#(
    parameter int W     = 8,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                       mclk,
    input  wire logic                       rst,
    // Fill side
    input  wire logic                       in_valid,
    input  wire logic [W-1:0]               in_data,
    output logic                            in_ready,
    // Drain side
    output logic                            out_valid,
    output logic [W-1:0]                    out_data,
    input  wire logic                       out_ready,
    // Fill level
    output logic [$clog2(DEPTH+1)-1:0]      count
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [CW-1:0]           cnt;
    } vcu_fifo_st_t;
    vcu_fifo_st_t s;
    vcu_fifo_st_t next_s;
    logic         push;
    logic         pop;
    assign in_ready  = s.cnt != CW'(DEPTH);
    assign out_valid = s.cnt != '0;
    assign out_data  = s.mem[s.rp];
    assign count     = s.cnt;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
        end
        if (pop) begin
            next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
        end
        next_s.cnt = s.cnt + CW'(push) - CW'(pop);
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule
`default_nettype wire

// ==== vcu_tgt.sv ====
// Target end: UART with enable and RTS/CTS style flow control
`timescale 1ns/1ps
`default_nettype none
module vcu_tgt
    import vcu_pkg::*;
#(
    parameter logic [15:0] DIV = DIV_DEF
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // Serial link
    vcu_if.tgt              lnk,
    // Control
    input  wire logic       path_en,
    input  wire logic       flow_en,
    // Transmit stream
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready,
    // Receive stream
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    input  wire logic       rx_ready
);
    typedef struct packed {
        logic        en;
        logic        txr;
        vcu_ln_t     tst;
        logic [9:0]  tsh;
        logic [3:0]  tbit;
        logic [15:0] tcnt;
        vcu_ln_t     rxst;
        logic [7:0]  rsh;
        logic [3:0]  rbit;
        logic [15:0] rcnt;
        logic        push;
        logic        trdy;
    } vcu_tgt_st_t;

    localparam vcu_tgt_st_t RST_ST = '{
        en: 1'b0, txr: 1'b0, tst: LN_IDLE, tsh: 10'h3FF, tbit: 4'h0,
        tcnt: 16'h0, rxst: LN_IDLE, rsh: 8'h0, rbit: 4'h0, rcnt: 16'h0,
        push: 1'b0, trdy: 1'b0
    };

    vcu_tgt_st_t s;
    vcu_tgt_st_t next_s;
    logic [1:0]  f_cnt;

    vcu_fifo #(
        .W     (8),
        .DEPTH (FIFO_DEPTH)
    ) u_rxbuf (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (s.push),
        .in_data   (s.rsh),
        .in_ready  (),
        .out_valid (rx_valid),
        .out_data  (rx_data),
        .out_ready (rx_ready),
        .count     (f_cnt)
    );

    always_comb begin
        next_s      = s;
        next_s.push = 1'b0;
        next_s.en   = path_en;
        case (s.tst)
            LN_IDLE: begin
                if (tx_valid && s.txr) begin
                    next_s.tsh  = {1'b1, tx_data, 1'b0};
                    next_s.tbit = FRAME_BITS - 4'h1;
                    next_s.tcnt = DIV - 16'h1;
                    next_s.tst  = LN_BUSY;
                end
            end
            LN_BUSY: begin
                if (s.tcnt != 16'h0) begin
                    next_s.tcnt = s.tcnt - 16'h1;
                end else if (s.tbit == 4'h0) begin
                    next_s.tst = LN_IDLE;
                end else begin
                    next_s.tsh  = {1'b1, s.tsh[9:1]};
                    next_s.tbit = s.tbit - 4'h1;
                    next_s.tcnt = DIV - 16'h1;
                end
            end
            default: begin
                next_s.tst = LN_IDLE;
            end
        endcase
        case (s.rxst)
            LN_IDLE: begin
                if (s.en && !lnk.c2t) begin
                    next_s.rxst = LN_BUSY;
                    next_s.rcnt = {1'b0, DIV[15:1]};
                    next_s.rbit = 4'h0;
                end
            end
            LN_BUSY: begin
                if (s.rcnt != 16'h0) begin
                    next_s.rcnt = s.rcnt - 16'h1;
                end else begin
                    next_s.rcnt = DIV - 16'h1;
                    next_s.rbit = s.rbit + 4'h1;
                    if (s.rbit == 4'h0) begin
                        if (lnk.c2t) begin
                            next_s.rxst = LN_IDLE;
                        end
                    end else if (s.rbit != FRAME_BITS - 4'h1) begin
                        next_s.rsh = {lnk.c2t, s.rsh[7:1]};
                    end else begin
                        next_s.rxst = LN_IDLE;
                        next_s.push = lnk.c2t;
                    end
                end
            end
            default: begin
                next_s.rxst = LN_IDLE;
            end
        endcase
        // Ready to send only between frames, and with flow_en set only when the controller allows
        next_s.txr  = (next_s.tst == LN_IDLE) && next_s.en &&
                      (!flow_en || lnk.c_rdy);
        // Dropping ready at the first stored byte keeps room for one in flight
        next_s.trdy = (f_cnt == 2'h0);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s <= RST_ST;
        end else begin
            s <= next_s;
        end
    end

    assign lnk.t2c     = s.tsh[0];
    assign lnk.t_rdy   = s.trdy;
    assign lnk.link_en = s.en;
    assign tx_ready    = s.txr;
endmodule
`default_nettype wire

// ==== vcu_link_asserts.sv ====
// Assertions on the serial link between the controller and target ends
`timescale 1ns/1ps
`default_nettype none
module vcu_link_asserts #(
    parameter int DIV = 27
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Serial link
    input wire logic t2c,
    input wire logic c2t,
    input wire logic c_rdy_oe,
    input wire logic link_en
);
    // Cycle within a frame counted from the start bit, 0 on an idle line
    int fc;
    int ft;
    always_ff @(posedge mclk) begin
        fc <= (rst || fc == 10 * DIV - 1) ? 0 : (fc != 0 || !c2t) ? fc + 1 : 0;
        ft <= (rst || ft == 10 * DIV - 1) ? 0 : (ft != 0 || !t2c) ? ft + 1 : 0;
    end
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (rst);
    property p_reset_idle;
        $fell(rst) |-> c2t && t2c && !c_rdy_oe && !link_en;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("link busy after reset");
    property p_c2t_start;
        fc != 0 && fc < DIV |-> !c2t;
    endproperty
    a_c2t_start: assert property (p_c2t_start)
        else $error("c2t start bit short");
    property p_c2t_stable;
        fc % DIV != 0 |-> $stable(c2t);
    endproperty
    a_c2t_stable: assert property (p_c2t_stable)
        else $error("c2t bit changed early");
    property p_c2t_stop;
        fc >= 9 * DIV |-> c2t;
    endproperty
    a_c2t_stop: assert property (p_c2t_stop)
        else $error("c2t stop bit low");
    property p_t2c_start;
        ft != 0 && ft < DIV |-> !t2c;
    endproperty
    a_t2c_start: assert property (p_t2c_start)
        else $error("t2c start bit short");
    property p_t2c_stable;
        ft % DIV != 0 |-> $stable(t2c);
    endproperty
    a_t2c_stable: assert property (p_t2c_stable)
        else $error("t2c bit changed early");
    property p_t2c_stop;
        ft >= 9 * DIV |-> t2c;
    endproperty
    a_t2c_stop: assert property (p_t2c_stop)
        else $error("t2c stop bit low");
    // A start may follow the enable by one or two cycles of pipeline
    property p_c2t_gate;
        fc == 0 && !c2t |-> $past(link_en) || $past(link_en, 2);
    endproperty
    a_c2t_gate: assert property (p_c2t_gate)
        else $error("c2t frame without enable");
endmodule
`default_nettype wire

// ==== test_vcom_uart_flow_control.sv ====
// Self-checking bench for the controller and target ends joined by the link
`timescale 1ns/1ps
`default_nettype none
module test_vcom_uart_flow_control
    import vcu_pkg::*;
();
    localparam int DIV  = int'(DIV_MIN);
    localparam int CEIL = 20000;
    logic        mclk;
    logic        rst;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        path_en;
    logic        flow_en;
    logic        tx_valid;
    logic [7:0]  tx_data;
    logic        tx_ready;
    logic        rx_valid;
    logic [7:0]  rx_data;
    logic        rx_ready;
    logic [31:0] rd;
    int          failures;
    int          checks_done;
    int          cyc;

    vcu_if lnk ();
    vcu_ctrl vcu_ctrl_i (.mclk(mclk), .rst(rst), .lnk(lnk.ctrl),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    vcu_tgt #(.DIV(16'(DIV))) vcu_tgt_i (.mclk(mclk), .rst(rst), .lnk(lnk.tgt),
        .path_en(path_en), .flow_en(flow_en), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready));
    vcu_link_asserts #(.DIV(DIV)) vcu_link_asserts_i (.mclk(mclk), .rst(rst),
        .t2c(lnk.t2c), .c2t(lnk.c2t), .c_rdy_oe(lnk.c_rdy_oe), .link_en(lnk.link_en));

    initial mclk = 1'b0;
    always #20 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == CEIL) begin
            failures++;
            $display("mismatch at %0t: timeout", $time);
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string s);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h want %h", $time, s, seen, exp);
        end
    endtask

    task automatic chk1(input logic seen, input logic exp, input string s);
        check({31'h0, seen}, {31'h0, exp}, s);
    endtask

    function automatic logic line(input logic sel);
        return sel ? lnk.t2c : lnk.c2t;
    endfunction

    // Bus master: holds the request until waitrequest is seen low
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) @(posedge mclk);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic set_mode(input logic [1:0] m);
        av(1'b1, REG_CFG, {14'h0, m, DIV_MIN});
    endtask

    // Samples one frame mid-bit; returns at the middle of the stop bit
    task automatic frame(input logic sel, input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        @(posedge mclk);
        while (line(sel) !== 1'b0) @(posedge mclk);
        repeat (DIV / 2) @(posedge mclk);
        for (int i = 0; i < 10; i++) begin
            chk1(line(sel), f[i], "line bit");
            if (i < 9) repeat (DIV) @(posedge mclk);
        end
    endtask

    task automatic quiet(input logic sel, input int n);
        int lows;
        lows = 0;
        repeat (n) begin
            @(posedge mclk);
            if (line(sel) !== 1'b1) lows++;
        end
        check(lows, 0, "line quiet");
    endtask

    task automatic tgt_put(input logic [7:0] b);
        tx_valid <= 1'b1;
        tx_data  <= b;
        @(posedge mclk);
        while (tx_ready !== 1'b1) @(posedge mclk);
        tx_valid <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic tgt_get(input logic [7:0] b);
        while (rx_valid !== 1'b1) @(posedge mclk);
        check({24'h0, rx_data}, {24'h0, b}, "target rx");
        rx_ready <= 1'b1;
        @(posedge mclk);
        rx_ready <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic t_reset();
        chk1(lnk.c2t, 1'b1, "c2t idle");
        chk1(lnk.c_rdy_oe, 1'b0, "ready undriven");
        av(1'b0, REG_CFG, 32'h0);
        check(rd, {14'h0, HS_DEF, DIV_DEF}, "cfg default");
        av(1'b0, 4'h2, 32'h0);
        check(rd, 32'h0, "unmapped");
        av(1'b1, REG_CFG, {16'h0, DIV_MAX});
        av(1'b0, REG_CFG, 32'h0);
        check(rd, {16'h0, DIV_MAX}, "slowest");
        av(1'b1, REG_CFG, 32'hFFFF);
        av(1'b0, REG_CFG, 32'h0);
        check(rd, {16'h0, DIV_MAX}, "clamp high");
        av(1'b1, REG_CFG, 32'h1);
        av(1'b0, REG_CFG, 32'h0);
        check(rd, {16'h0, DIV_MIN}, "clamp low");
        // Mode lane only: a divisor in the refused lanes must not land
        avs_byteenable <= 4'h4;
        av(1'b1, REG_CFG, {14'h0, HS_RTS, DIV_MAX});
        avs_byteenable <= 4'hF;
        av(1'b0, REG_CFG, 32'h0);
        check(rd, {14'h0, HS_RTS, DIV_MIN}, "mode only");
        set_mode(HS_DISABLED);
        av(1'b0, REG_CFG, 32'h0);
        check(rd, {16'h0, DIV_MIN}, "fastest");
        $display("reset test done");
    endtask

    task automatic t_basic();
        fork
            av(1'b1, REG_TXD, 32'hA5);
            frame(1'b0, 8'hA5);
        join
        tgt_get(8'hA5);
        fork
            tgt_put(8'h3C);
            frame(1'b1, 8'h3C);
        join
        repeat (DIV) @(posedge mclk);
        av(1'b0, REG_RXD, 32'h0);
        check(rd, 32'h13C, "ctrl rx");
        $display("basic test done");
    endtask

    task automatic t_gate();
        path_en <= 1'b0;
        repeat (2) @(posedge mclk);
        av(1'b1, REG_TXD, 32'h5A);
        quiet(1'b0, 12 * DIV);
        chk1(tx_ready, 1'b0, "target held");
        path_en <= 1'b1;
        fork
            frame(1'b0, 8'h5A);
            tgt_get(8'h5A);
        join
        $display("gate test done");
    endtask

    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            set_mode(2'(m));
            @(posedge mclk);
            chk1(lnk.c_rdy_oe, 1'(m % 2), "ready drive");
            chk1(lnk.c_rdy, 1'b1, "ready idle");
        end
        $display("mode test done");
    endtask

    task automatic t_tflow();
        set_mode(HS_DISABLED);
        fork
            begin
                av(1'b1, REG_TXD, 32'h11);
                av(1'b1, REG_TXD, 32'h22);
            end
            begin
                frame(1'b0, 8'h11);
                frame(1'b0, 8'h22);
            end
        join
        chk1(lnk.t_rdy, 1'b0, "target full");
        tgt_get(8'h11);
        tgt_get(8'h22);
        set_mode(HS_CTS);
        fork
            av(1'b1, REG_TXD, 32'h33);
            frame(1'b0, 8'h33);
        join
        repeat (DIV) @(posedge mclk);
        av(1'b1, REG_TXD, 32'h44);
        quiet(1'b0, 12 * DIV);
        av(1'b0, REG_STAT, 32'h0);
        check(rd, 32'h1A, "tx pending");
        fork
            tgt_get(8'h33);
            frame(1'b0, 8'h44);
        join
        tgt_get(8'h44);
        $display("target flow test done");
    endtask

    task automatic t_rts();
        set_mode(HS_RTSCTS);
        flow_en <= 1'b1;
        tgt_put(8'h01);
        repeat (11 * DIV) @(posedge mclk);
        chk1(lnk.c_rdy, 1'b1, "room left");
        tgt_put(8'h02);
        repeat (11 * DIV) @(posedge mclk);
        chk1(lnk.c_rdy, 1'b0, "ctrl full");
        fork
            tgt_put(8'h03);
            begin
                quiet(1'b1, 12 * DIV);
                av(1'b0, REG_RXD, 32'h0);
                check(rd, 32'h101, "first");
                av(1'b0, REG_RXD, 32'h0);
                check(rd, 32'h102, "second");
            end
        join
        repeat (11 * DIV) @(posedge mclk);
        av(1'b0, REG_RXD, 32'h0);
        check(rd, 32'h103, "third");
        $display("controller flow test done");
    endtask

    // Target ignores controller-ready, so a third byte overruns the full buffer
    task automatic t_ovr();
        flow_en <= 1'b0;
        tgt_put(8'h61);
        tgt_put(8'h62);
        tgt_put(8'h63);
        repeat (11 * DIV) @(posedge mclk);
        av(1'b0, REG_STAT, 32'h0);
        check(rd, 32'h2D, "overrun set");
        av(1'b0, REG_STAT, 32'h0);
        check(rd, 32'h0D, "overrun clear");
        $display("overrun test done");
    endtask

    initial begin
        rst            = 1'b1;
        avs_address    = 4'h0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'hF;
        path_en        = 1'b1;
        flow_en        = 1'b0;
        tx_valid       = 1'b0;
        tx_data        = 8'h0;
        rx_ready       = 1'b0;
        failures       = 0;
        checks_done    = 0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_basic();
        t_gate();
        t_modes();
        t_tflow();
        t_rts();
        t_ovr();
        test_done();
    end
endmodule
`default_nettype wire
